// file: core/ddr_port_defs.svh
// Purpose: Constants for the DDR SDRAM command and address front end.
// Assumes: One 50 MHz clock; the controller drives pins on that clock.
// Notes:   Mode field positions and precharge time are local choices.
//
// What this block does
// - Sample all address and control inputs on the rising clock edge.
// - Move read and write data as one word per clock half.
// - Bursts run 2, 4 or 8 words from the start column.
// - Column order inside a burst is sequential or interleaved.
// - First read word appears 2, 2.5 or 3 clocks after the read.
// - Auto close starts a self-timed precharge at the burst end, unless a read or write is issued during the burst.
// - Clock enable low freezes all outputs except the power state, the burst address included, from next cycle.
// - Clock enable low with all banks idle enters power-down or self refresh.
// - Bank select picks the bank for open, read, write and, with line ten low, precharge.
// - Row open takes all thirteen address lines as the row.
// - Read or write takes ten low lines as column, line ten as auto close.
// - Each byte lane has a write mask aligned with its data beat.
// - Extended mode set command switches the delay-locked loop on or off.
// - Storage is four banks of 8M words by 16 bits.
// - Chip select high makes the decoder ignore the command.
// - Row strobe low, column strobe high: open or precharge by write enable.
// - Column strobe low, row strobe high: read or write by write enable.
// - A masked byte lane is left unwritten during a write beat.
`ifndef DDR_PORT_DEFS_SVH
`define DDR_PORT_DEFS_SVH

// Array geometry
`define BANKS       4
`define BANK_W      2
`define ROW_W       13
`define COL_W       10
`define WORD_W      16
`define AP_BIT      10

// Mode register fields, taken from address lines
`define MR_BL_LSB   0
`define MR_BT_BIT   3
`define MR_CL_LSB   4
`define BL_CODE_2   3'h1
`define BL_CODE_4   3'h2
`define BL_CODE_8   3'h3
`define CL_CODE_2   3'h2
`define CL_CODE_25  3'h6
`define CL_CODE_3   3'h3
`define EMR_DLL_OFF 0
`define SEL_MODE    2'h0
`define SEL_EXT     2'h1

// Reset values
`define RST_BL      3'h1
`define RST_CL      3'h2

// Timing
`define CLK_NS      20
`define RP_NS       15
`define RP_CYC      ((`RP_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W       4

`endif

// file: core/ddr_port_pkg.sv
// Purpose: Shared types of the DDR SDRAM command and address front end.
// Assumes: Constants come from the defs header.
// Notes:   Structs are packed so they travel as single ports.
`include "ddr_port_defs.svh"

package ddr_port_pkg;

  // Decoded command
  typedef enum logic [2:0] {
    CMD_NOP     = 3'h0,
    CMD_OPEN    = 3'h1,
    CMD_READ    = 3'h2,
    CMD_WRITE   = 3'h3,
    CMD_PRECH   = 3'h4,
    CMD_REFRESH = 3'h5,
    CMD_MODE    = 3'h6,
    CMD_DESEL   = 3'h7
  } cmd_e;

  // Power state
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_DOWN   = 2'h1,
    PWR_SELF   = 2'h2,
    PWR_SUSP   = 2'h3
  } pwr_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } cmd_pins_s;

  typedef struct packed {
    logic [2:0] cl;
    logic       interleave;
    logic [2:0] bl;
  } mode_s;

  typedef struct packed {
    logic                 open;
    logic [`CNT_W-1:0]    cnt;
    logic [`ROW_W-1:0]    row;
  } bank_s;

  typedef struct packed {
    logic                 en;
    logic [`BANK_W-1:0]   bank;
    logic [`ROW_W-1:0]    row;
    logic [`COL_W-1:0]    col0;
    logic [`COL_W-1:0]    col1;
  } arr_rd_s;

  typedef struct packed {
    logic                 en;
    logic [`BANK_W-1:0]   bank;
    logic [`ROW_W-1:0]    row;
    logic [`COL_W-1:0]    col0;
    logic [`COL_W-1:0]    col1;
    logic [`WORD_W-1:0]   data0;
    logic [`WORD_W-1:0]   data1;
    logic [1:0]           be0;
    logic [1:0]           be1;
  } arr_wr_s;

endpackage : ddr_port_pkg

// file: core/burst_col_gen.sv
// Purpose: Burst column generator, two columns per clock.
// Assumes: load only comes while run is high.
// Notes:   Holds every register while run is low.
`timescale 1ns/10ps
`include "ddr_port_defs.svh"

module burst_col_gen #(
  parameter int COL_W = `COL_W
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             load,
  input  wire logic             load_wr,
  input  wire logic             run,
  input  wire logic [COL_W-1:0] start_col,
  input  wire logic [3:0]       bl_words,
  input  wire logic             interleave,
  output logic                  rd_act,
  output logic                  wr_act,
  output logic                  last,
  output logic [COL_W-1:0]      col0,
  output logic [COL_W-1:0]      col1
);

  logic [COL_W-1:0] start_r, start_nxt, col0_r, col0_nxt, col1_r, col1_nxt;
  logic [3:0]       bl_r, bl_nxt, idx_r, idx_nxt;
  logic             il_r, il_nxt, rd_r, rd_nxt, wr_r, wr_nxt;
  logic             last_r, last_nxt;

  // Column of beat idx; wraps inside the burst-aligned block
  function automatic logic [COL_W-1:0] col_at(input logic [COL_W-1:0] s,
      input logic [3:0] idx, input logic [3:0] bl, input logic il);
    logic [COL_W-1:0] m;
    logic [COL_W-1:0] i;
    logic [COL_W-1:0] off;
    m   = {{(COL_W-4){1'b0}}, bl} - {{(COL_W-1){1'b0}}, 1'b1};
    i   = {{(COL_W-4){1'b0}}, idx};
    off = il ? (s ^ i) : (s + i);
    return (s & ~m) | (off & m);
  endfunction : col_at

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    start_nxt = start_r;
    bl_nxt    = bl_r;
    il_nxt    = il_r;
    idx_nxt   = idx_r;
    col0_nxt  = col0_r;
    col1_nxt  = col1_r;
    rd_nxt    = rd_r;
    wr_nxt    = wr_r;
    last_nxt  = last_r;
    if (run) begin
      if (load) begin
        start_nxt = start_col;
        bl_nxt    = bl_words;
        il_nxt    = interleave;
        col0_nxt  = col_at(start_col, 4'h0, bl_words, interleave);
        col1_nxt  = col_at(start_col, 4'h1, bl_words, interleave);
        idx_nxt   = 4'h2;
        rd_nxt    = !load_wr;
        wr_nxt    = load_wr;
        last_nxt  = (bl_words == 4'h2);
      end else if (rd_r || wr_r) begin
        if (last_r) begin
          rd_nxt   = 1'b0;
          wr_nxt   = 1'b0;
          last_nxt = 1'b0;
        end else begin
          col0_nxt = col_at(start_r, idx_r, bl_r, il_r);
          col1_nxt = col_at(start_r, idx_r + 4'h1, bl_r, il_r);
          idx_nxt  = idx_r + 4'h2;
          last_nxt = ((idx_r + 4'h2) >= bl_r);
        end
      end
    end
  end

  // Registers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      start_r <= '0;
      bl_r    <= 4'h2;
      il_r    <= 1'b0;
      idx_r   <= 4'h0;
      col0_r  <= '0;
      col1_r  <= '0;
      rd_r    <= 1'b0;
      wr_r    <= 1'b0;
      last_r  <= 1'b0;
    end else begin
      start_r <= start_nxt;
      bl_r    <= bl_nxt;
      il_r    <= il_nxt;
      idx_r   <= idx_nxt;
      col0_r  <= col0_nxt;
      col1_r  <= col1_nxt;
      rd_r    <= rd_nxt;
      wr_r    <= wr_nxt;
      last_r  <= last_nxt;
    end
  end

  assign rd_act = rd_r;
  assign wr_act = wr_r;
  assign last   = last_r;
  assign col0   = col0_r;
  assign col1   = col1_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks; a cut or frozen burst keeps the length check quiet
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_bl8_run;
    load && run && bl_words == 4'h8 ##1 (run && !load)[*4];
  endsequence

  a_burst_len: assert property (s_bl8_run |-> rd_act || wr_act ##1
    !rd_act && !wr_act)
    else $error("burst of eight wrong length");
  a_col_start: assert property (load && run |=>
    col0 == $past(start_col))
    else $error("burst start column wrong");
  a_col_order: assert property (load && run |=>
    ($past(interleave) ? col1[1:0] == (col0[1:0] ^ 2'h1)
     : ($past(bl_words) == 4'h2 || col1[1:0] == col0[1:0] + 2'h1)))
    else $error("burst column order wrong");

endmodule : burst_col_gen

// file: core/ddr_sdram_cmd_addr_port.sv
// Purpose: Command, address and clock-enable front end of a 4-bank DDR DRAM.
// Assumes: Pins arrive on this clock; the array answers reads combinationally.
// Notes:   Data is carried as a rise word and a fall word per clock.
`timescale 1ns/10ps
`include "ddr_port_defs.svh"

module ddr_sdram_cmd_addr_port #(
  parameter int RP_CYCLES = `RP_CYC
) (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      cke,
  input  wire ddr_port_pkg::cmd_pins_s   cmd,
  input  wire logic [`BANK_W-1:0]        bank_select,
  input  wire logic [`ROW_W-1:0]         addr,
  input  wire logic [`WORD_W-1:0]        wdata_rise,
  input  wire logic [`WORD_W-1:0]        wdata_fall,
  input  wire logic [1:0]                byte_write_mask_rise,
  input  wire logic [1:0]                byte_write_mask_fall,
  input  wire logic [`WORD_W-1:0]        arr_rdata0,
  input  wire logic [`WORD_W-1:0]        arr_rdata1,
  output ddr_port_pkg::arr_rd_s          arr_rd,
  output ddr_port_pkg::arr_wr_s          arr_wr,
  output logic [`WORD_W-1:0]             rdata_rise,
  output logic [`WORD_W-1:0]             rdata_fall,
  output logic                           rvalid_rise,
  output logic                           rvalid_fall,
  output logic [`BANKS-1:0]              bank_open,
  output ddr_port_pkg::pwr_e             pwr_state,
  output logic                           dll_enable
);

  ddr_port_pkg::cmd_e    cur;
  ddr_port_pkg::mode_s   mode_r, mode_nxt;
  ddr_port_pkg::bank_s   bank_r [`BANKS];
  ddr_port_pkg::bank_s   bank_nxt [`BANKS];
  ddr_port_pkg::pwr_e    pwr_r, pwr_nxt;
  ddr_port_pkg::arr_wr_s wr_r, wr_nxt;
  logic                  cke_r, run, cmd_ok, load, end_burst, all_idle;
  logic                  dll_r, dll_nxt, ap_r, ap_nxt;
  logic [`BANK_W-1:0]    bb_r, bb_nxt;
  logic [`ROW_W-1:0]     brow_r, brow_nxt;
  logic                  rd_act, wr_act, last, auto_close_flag_line;
  logic [`COL_W-1:0]     col0, col1;
  logic                  p1v_r, p1v_nxt, vr_r, vr_nxt, vf_r, vf_nxt;
  logic [`WORD_W-1:0]    p1w0_r, p1w0_nxt, p1w1_r, p1w1_nxt;
  logic [`WORD_W-1:0]    rr_r, rr_nxt, rf_r, rf_nxt;
  logic [`BANKS-1:0]     idle_v;
  logic [3:0]            bl_words;

  function automatic ddr_port_pkg::cmd_e decode(
      input ddr_port_pkg::cmd_pins_s c);
    if (c.cs_n) return ddr_port_pkg::CMD_DESEL;
    case ({c.ras_n, c.cas_n, c.we_n})
      3'h3:    return ddr_port_pkg::CMD_OPEN;
      3'h2:    return ddr_port_pkg::CMD_PRECH;
      3'h5:    return ddr_port_pkg::CMD_READ;
      3'h4:    return ddr_port_pkg::CMD_WRITE;
      3'h1:    return ddr_port_pkg::CMD_REFRESH;
      3'h0:    return ddr_port_pkg::CMD_MODE;
      default: return ddr_port_pkg::CMD_NOP;
    endcase
  endfunction : decode

  ////////////////////////////////////////////////////////////////////////
  // Command qualification; commands count only with clock enable held high, save refresh with clock enable low for self refresh entry
  assign cur    = decode(cmd);
  assign run    = cke_r;
  assign cmd_ok = cke && cke_r;
  assign auto_close_flag_line = addr[`AP_BIT];
  assign load   = cmd_ok && (cur == ddr_port_pkg::CMD_READ ||
                             cur == ddr_port_pkg::CMD_WRITE);
  assign end_burst = run && last && (rd_act || wr_act) && !load;
  assign all_idle  = (&idle_v) && !rd_act && !wr_act;
  assign bl_words  = (mode_r.bl == `BL_CODE_8) ? 4'h8 :
                     (mode_r.bl == `BL_CODE_4) ? 4'h4 : 4'h2;

  burst_col_gen #(.COL_W(`COL_W)) u_gen (
    .clock      (clock),
    .rst_n      (rst_n),
    .load       (load),
    .load_wr    (cur == ddr_port_pkg::CMD_WRITE),
    .run        (run),
    .start_col  (addr[`COL_W-1:0]),
    .bl_words   (bl_words),
    .interleave (mode_r.interleave),
    .rd_act     (rd_act),
    .wr_act     (wr_act),
    .last       (last),
    .col0       (col0),
    .col1       (col1)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-bank row state and self-timed precharge
  // four independent banks
  for (genvar b = 0; b < `BANKS; b++) begin : g_bank
    always_comb begin
      bank_nxt[b] = bank_r[b];
      if (bank_r[b].cnt != '0)
        bank_nxt[b].cnt = bank_r[b].cnt - `CNT_W'(1);
      if (cmd_ok && cur == ddr_port_pkg::CMD_OPEN &&
          bank_select == `BANK_W'(b)) begin
        bank_nxt[b].open = 1'b1;
        bank_nxt[b].row  = addr;
      end
      if (cmd_ok && cur == ddr_port_pkg::CMD_PRECH &&
          (auto_close_flag_line || bank_select == `BANK_W'(b))) begin
        bank_nxt[b].open = 1'b0;
        bank_nxt[b].cnt  = `CNT_W'(RP_CYCLES);
      end
      if (end_burst && ap_r && bb_r == `BANK_W'(b)) begin
        bank_nxt[b].open = 1'b0;
        bank_nxt[b].cnt  = `CNT_W'(RP_CYCLES);
      end
    end
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) bank_r[b] <= '0;
      else        bank_r[b] <= bank_nxt[b];
    end
    assign idle_v[b]    = !bank_r[b].open && bank_r[b].cnt == '0;
    assign bank_open[b] = bank_r[b].open;
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode registers, burst context and power state
  always_comb begin
    mode_nxt = mode_r;
    dll_nxt  = dll_r;
    ap_nxt   = ap_r;
    bb_nxt   = bb_r;
    brow_nxt = brow_r;
    pwr_nxt  = pwr_r;
    if (cmd_ok && cur == ddr_port_pkg::CMD_MODE) begin
      if (bank_select == `SEL_MODE) begin
        mode_nxt.bl = addr[`MR_BL_LSB +: 3];
        mode_nxt.interleave = addr[`MR_BT_BIT];
        mode_nxt.cl = addr[`MR_CL_LSB +: 3];
      end
      if (bank_select == `SEL_EXT)
        dll_nxt = !addr[`EMR_DLL_OFF];
    end
    // burst bank, open row and auto close flag
    if (load) begin
      ap_nxt   = auto_close_flag_line;
      bb_nxt   = bank_select;
      brow_nxt = bank_r[bank_select].row;
    end
    case (pwr_r)
      ddr_port_pkg::PWR_ACTIVE: begin
        if (!cke) begin
          if (!all_idle)
            pwr_nxt = ddr_port_pkg::PWR_SUSP;
          else if (cur == ddr_port_pkg::CMD_REFRESH)
            pwr_nxt = ddr_port_pkg::PWR_SELF;
          else
            pwr_nxt = ddr_port_pkg::PWR_DOWN;
        end
      end
      ddr_port_pkg::PWR_DOWN, ddr_port_pkg::PWR_SELF,
      ddr_port_pkg::PWR_SUSP: begin
        if (cke) pwr_nxt = ddr_port_pkg::PWR_ACTIVE;
      end
      default: pwr_nxt = ddr_port_pkg::PWR_ACTIVE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Data paths; both clock halves carry one word each
  always_comb begin
    wr_nxt   = wr_r;
    p1v_nxt  = p1v_r;
    p1w0_nxt = p1w0_r;
    p1w1_nxt = p1w1_r;
    rr_nxt   = rr_r;
    rf_nxt   = rf_r;
    vr_nxt   = vr_r;
    vf_nxt   = vf_r;
    if (run) begin
      wr_nxt = '{en: wr_act, bank: bb_r, row: brow_r, col0: col0,
                 col1: col1, data0: wdata_rise, data1: wdata_fall,
                 be0: ~byte_write_mask_rise, be1: ~byte_write_mask_fall};
      p1v_nxt  = rd_act;
      p1w0_nxt = arr_rdata0;
      p1w1_nxt = arr_rdata1;
      case (mode_r.cl)
        `CL_CODE_3: begin
          rr_nxt = p1w0_r;
          vr_nxt = p1v_r;
          rf_nxt = p1w1_r;
          vf_nxt = p1v_r;
        end
        `CL_CODE_25: begin
          rr_nxt = p1w1_r;
          vr_nxt = p1v_r;
          rf_nxt = arr_rdata0;
          vf_nxt = rd_act;
        end
        default: begin
          rr_nxt = arr_rdata0;
          vr_nxt = rd_act;
          rf_nxt = arr_rdata1;
          vf_nxt = rd_act;
        end
      endcase
    end
  end

  // all pins sampled on the rising edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cke_r  <= 1'b0;
      mode_r <= '{cl: `RST_CL, interleave: 1'b0, bl: `RST_BL};
      dll_r  <= 1'b1;
      {ap_r, bb_r, brow_r} <= '0;
      pwr_r  <= ddr_port_pkg::PWR_ACTIVE;
      wr_r   <= '0;
      {p1v_r, p1w0_r, p1w1_r} <= '0;
      {rr_r, rf_r, vr_r, vf_r} <= '0;
    end else begin
      cke_r  <= cke;
      mode_r <= mode_nxt;
      dll_r  <= dll_nxt;
      {ap_r, bb_r, brow_r} <= {ap_nxt, bb_nxt, brow_nxt};
      pwr_r  <= pwr_nxt;
      wr_r   <= wr_nxt;
      {p1v_r, p1w0_r, p1w1_r} <= {p1v_nxt, p1w0_nxt, p1w1_nxt};
      {rr_r, rf_r, vr_r, vf_r} <= {rr_nxt, rf_nxt, vr_nxt, vf_nxt};
    end
  end

  assign arr_rd      = '{en: rd_act, bank: bb_r, row: brow_r,
                         col0: col0, col1: col1};
  assign arr_wr      = wr_r;
  assign rdata_rise  = rr_r;
  assign rdata_fall  = rf_r;
  assign rvalid_rise = vr_r;
  assign rvalid_fall = vf_r;
  assign pwr_state   = pwr_r;
  assign dll_enable  = dll_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence s_rd;
    cmd_ok && cur == ddr_port_pkg::CMD_READ;
  endsequence

  a_desel_ignored: assert property (cmd.cs_n |=>
    (bank_open & ~$past(bank_open)) == '0)
    else $error("bank opened while deselected");
  a_row_open: assert property (
    cmd_ok && cur == ddr_port_pkg::CMD_OPEN |=>
    bank_open[$past(bank_select)] &&
    bank_r[$past(bank_select)].row == $past(addr))
    else $error("row open not captured");
  a_lat_two: assert property (
    s_rd and mode_r.cl == `CL_CODE_2 |-> ##2 rvalid_rise && rvalid_fall)
    else $error("read latency 2 missed");
  a_lat_half: assert property (
    s_rd and mode_r.cl == `CL_CODE_25 |-> ##2 rvalid_fall)
    else $error("read latency 2.5 missed");
  a_lat_three: assert property (
    (s_rd and mode_r.cl == `CL_CODE_3) ##1 cke |-> ##2 rvalid_rise)
    else $error("read latency 3 missed");
  a_freeze_out: assert property (!cke_r |=> $stable(rdata_rise) &&
    $stable(rvalid_rise) && $stable(col0))
    else $error("state moved while suspended");
  a_mask_lane: assert property (wr_act && cke_r |=> arr_wr.en &&
    arr_wr.be0 == ~$past(byte_write_mask_rise))
    else $error("write mask not applied");
  a_auto_close: assert property (end_burst && ap_r |=>
    !bank_open[$past(bb_r)] && bank_r[$past(bb_r)].cnt != '0)
    else $error("auto close missed");
  a_dll_set: assert property (cmd_ok && cur == ddr_port_pkg::CMD_MODE &&
    bank_select == `SEL_EXT |=> dll_enable == !$past(addr[0]))
    else $error("loop enable not set");
  a_pwr_entry: assert property (pwr_r == ddr_port_pkg::PWR_ACTIVE &&
    !cke && all_idle && cur != ddr_port_pkg::CMD_REFRESH |=>
    pwr_state == ddr_port_pkg::PWR_DOWN)
    else $error("power-down not entered");

endmodule : ddr_sdram_cmd_addr_port

// file: sim/array_model.sv
// Purpose: Array stand-in that answers reads in the same cycle.
// Assumes: Word pattern is bank, column and low row bits.
// Notes:   An idle bus returns inverted words so stale data fails.
`timescale 1ns/10ps
module array_model (
  input  wire ddr_port_pkg::arr_rd_s rd,
  output logic [15:0]                d0,
  output logic [15:0]                d1
);
  // Bank, row and column pick the word
  always_comb begin
    d0 = {rd.bank, rd.col0, rd.row[3:0]};
    d1 = {rd.bank, rd.col1, rd.row[3:0]};
    if (!rd.en) begin
      d0 = ~d0;
      d1 = ~d1;
    end
  end
endmodule : array_model

// file: sim/test_ddr_sdram_cmd_addr_port.sv
// Purpose: Self-checking bench of the command and address front end.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Random addresses from a fixed seed, corner cases by hand.
`timescale 1ns/10ps
`include "ddr_port_defs.svh"
module test_ddr_sdram_cmd_addr_port;
  localparam int RP = 2;
  logic                    clock, rst_n, cke;
  ddr_port_pkg::cmd_pins_s cmd;
  logic [1:0]              bank_select, bmr, bmf, ck_h;
  logic [12:0]             addr;
  logic [15:0]             wdr, wdf, ad0, ad1, rdata_rise, rdata_fall;
  ddr_port_pkg::arr_rd_s   arr_rd;
  ddr_port_pkg::arr_wr_s   arr_wr;
  logic                    rvalid_rise, rvalid_fall, dll_enable;
  logic [3:0]              bank_open;
  ddr_port_pkg::pwr_e      pwr_state;
  int                      miscompares, checks_done, seed, cur_bl, cur_lat;
  logic                    cur_il, cur_half;

  ddr_sdram_cmd_addr_port #(.RP_CYCLES(RP)) u_ddr_sdram_cmd_addr_port (
    .clock(clock), .rst_n(rst_n), .cke(cke), .cmd(cmd),
    .bank_select(bank_select), .addr(addr), .wdata_rise(wdr),
    .wdata_fall(wdf), .byte_write_mask_rise(bmr),
    .byte_write_mask_fall(bmf), .arr_rdata0(ad0), .arr_rdata1(ad1),
    .arr_rd(arr_rd), .arr_wr(arr_wr), .rdata_rise(rdata_rise),
    .rdata_fall(rdata_fall), .rvalid_rise(rvalid_rise),
    .rvalid_fall(rvalid_fall), .bank_open(bank_open),
    .pwr_state(pwr_state), .dll_enable(dll_enable));
  array_model u_array_model (.rd(arr_rd), .d0(ad0), .d1(ad1));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, and a record of clock enable at the last two edges
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) ck_h <= {ck_h[0], cke};

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Command held for exactly one rising edge, returns one cycle later
  task automatic issue(input logic [3:0] c, input logic [1:0] b,
                       input logic [12:0] a);
    @(negedge clock);
    cmd = c;
    bank_select = b;
    addr = a;
    @(negedge clock);
    cmd = 4'h7;
  endtask : issue

  // Column of beat i, wrapping inside the aligned block
  function automatic logic [9:0] col_at(input logic [9:0] c, input int i);
    logic [9:0] m;
    m = 10'(cur_bl - 1);
    col_at = cur_il ? ((c & ~m) | ((c ^ 10'(i)) & m))
                    : ((c & ~m) | ((c + 10'(i)) & m));
  endfunction : col_at

  task automatic set_mode(input logic [2:0] bl, input logic il,
                          input logic [2:0] cl);
    issue(4'h0, `SEL_MODE, {6'h00, cl, il, bl});
    cur_bl = (bl == `BL_CODE_8) ? 8 : (bl == `BL_CODE_4) ? 4 : 2;
    cur_il = il;
    cur_lat = (cl == `CL_CODE_3) ? 3 : 2;
    cur_half = (cl == `CL_CODE_25);
  endtask : set_mode

  task automatic open(input logic [1:0] b, input logic [12:0] row);
    issue(4'h3, b, row);
    check(bank_open, 4'h1 << b);
  endtask : open

  task automatic prech(input logic [1:0] b, input logic all);
    issue(4'h2, b, {2'h0, all, 10'h000});
    check(bank_open, 4'h0);
  endtask : prech

  // Collect words in time order; frozen cycles are skipped
  task automatic rd_burst(input logic [1:0] b, input logic [12:0] row,
                          input logic [9:0] c, input logic ap,
                          input logic stall);
    int n;
    int k;
    int first;
    logic fall1;
    k = 0;
    first = 0;
    fall1 = 1'b0;
    issue(4'h5, b, {2'h0, ap, c});
    check({arr_rd.en, arr_rd.row}, {1'b1, row});
    for (n = 1; n < 30 && k < cur_bl; n++) begin
      if (ck_h[1] && rvalid_rise) begin
        first = (k == 0) ? n : first;
        check(rdata_rise, {b, col_at(c, k), row[3:0]});
        k++;
      end
      if (ck_h[1] && rvalid_fall) begin
        fall1 = (k == 0) ? 1'b1 : fall1;
        first = (k == 0) ? n : first;
        check(rdata_fall, {b, col_at(c, k), row[3:0]});
        k++;
      end
      if (stall && n == 1) cke = 1'b0;
      if (stall && n == 4) begin
        check(pwr_state, ddr_port_pkg::PWR_SUSP);
        cke = 1'b1;
      end
      @(negedge clock);
    end
    check(k, cur_bl);
    if (!stall) check({first, fall1}, {cur_lat, cur_half});
  endtask : rd_burst

  // Write beats go in one cycle after the command, masks alongside
  task automatic wr_burst(input logic [1:0] b, input logic [12:0] row,
                          input logic [9:0] c);
    logic [15:0] d [8];
    logic [1:0] m [8];
    int k;
    for (k = 0; k < 8; k++) begin
      d[k] = 16'($random(seed));
      m[k] = 2'($random(seed));
    end
    issue(4'h4, b, {3'h0, c});
    for (k = 0; k <= cur_bl / 2; k++) begin
      if (k > 0) check({arr_wr.en, arr_wr.bank, arr_wr.row, arr_wr.col0,
        arr_wr.data0, arr_wr.data1, arr_wr.be0, arr_wr.be1},
        {1'b1, b, row, col_at(c, 2*k-2), d[2*k-2], d[2*k-1],
        ~m[2*k-2], ~m[2*k-1]});
      if (k < cur_bl / 2) begin
        {wdr, wdf, bmr, bmf} = {d[2*k], d[2*k+1], m[2*k], m[2*k+1]};
      end
      @(negedge clock);
    end
    check(arr_wr.en, 1'b0);
  endtask : wr_burst

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    #(20 * 20000);
    miscompares++;
    finish_test();
  end

  // Main sequence
  initial begin
    logic [2:0] clt [3];
    logic [1:0] b;
    logic [12:0] row;
    int i;
    clt = '{`CL_CODE_2, `CL_CODE_25, `CL_CODE_3};
    seed = 74;
    {rst_n, cke, cmd, bank_select, addr} = {2'b01, 4'h7, 15'h0};
    {wdr, wdf, bmr, bmf} = 36'h0;
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    @(negedge clock);
    check({bank_open, dll_enable, pwr_state}, {4'h0, 1'b1, 2'h0});
    // Loop switched by extended mode set
    issue(4'h0, `SEL_EXT, 13'h0001);
    check(dll_enable, 1'b0);
    issue(4'h0, `SEL_EXT, 13'h0000);
    check(dll_enable, 1'b1);
    $display("mode set test done");
    for (i = 0; i < 12; i++) begin
      set_mode(3'(i / 4 + 1), 1'(i / 2), clt[i % 3]);
      b = 2'($random(seed));
      row = 13'($random(seed));
      open(b, row);
      rd_burst(b, row, 10'($random(seed)), 1'b0, 1'b0);
      prech(b, 1'(i));
      $display("read case %0d done", i);
    end
    set_mode(`BL_CODE_4, 1'b0, `CL_CODE_2);
    open(2'h2, 13'h1ABC);
    wr_burst(2'h2, 13'h1ABC, 10'($random(seed)));
    prech(2'h2, 1'b1);
    $display("write test done");
    set_mode(`BL_CODE_8, 1'b1, `CL_CODE_2);
    open(2'h1, 13'h0F0F);
    rd_burst(2'h1, 13'h0F0F, 10'h3FD, 1'b0, 1'b1);
    prech(2'h1, 1'b1);
    $display("suspend test done");
    set_mode(`BL_CODE_4, 1'b0, `CL_CODE_3);
    open(2'h3, 13'h0123);
    rd_burst(2'h3, 13'h0123, 10'h006, 1'b1, 1'b0);
    repeat (RP + 2) @(negedge clock);
    check(bank_open, 4'h0);
    issue(4'hB, 2'h0, 13'h0000);
    check(bank_open, 4'h0);
    $display("auto close and deselect done");
    // Idle entry to power-down, then self refresh
    for (i = 0; i < 2; i++) begin
      @(negedge clock);
      cmd = i ? 4'h1 : 4'h7;
      cke = 1'b0;
      @(negedge clock);
      cmd = 4'h7;
      repeat (2) @(negedge clock);
      check(pwr_state, i ? 2'h2 : 2'h1);
      cke = 1'b1;
      repeat (3) @(negedge clock);
      check(pwr_state, ddr_port_pkg::PWR_ACTIVE);
    end
    $display("power test done");
    finish_test();
  end
endmodule : test_ddr_sdram_cmd_addr_port
